// [pvi_regs.vh]
// Field positions, encodings and sequence constants of the vector/init controller
`ifndef PVI_REGS_VH
`define PVI_REGS_VH

// First init word fields (written with select line low, bit 4 high)
`define PVI_W1_NEED4_BIT     0
`define PVI_W1_LONE_BIT      1
`define PVI_W1_SPACE4_BIT    2
`define PVI_W1_LEVEL_BIT     3
`define PVI_W1_MARK_BIT      4

// Fourth init word fields
`define PVI_W4_VECMODE_BIT   0
`define PVI_W4_AUTO_BIT      1
`define PVI_W4_MASTER_BIT    2
`define PVI_W4_BUF_BIT       3
`define PVI_W4_NEST_BIT      4

// Operation words
`define PVI_OP_SEL3_BIT      3
`define PVI_OP_EOI_BIT       5
`define PVI_OP_SPEC_BIT      6
`define PVI_OP_RDREG_BIT     1
`define PVI_OP_RDISR_BIT     0
`define PVI_OP_SMM_BIT       5
`define PVI_OP_ESMM_BIT      6

// Reset values
`define PVI_MASK_RST         8'h00
`define PVI_WORD_RST         8'h00

// Vector bytes and levels
`define PVI_CALL_OPCODE      8'hCD
`define PVI_FALLBACK_LEVEL   3'h7
`define PVI_CASC_IDLE        3'h0

// Acknowledge pulses per sequence
`define PVI_CALL_PULSES      2'h3
`define PVI_VEC_PULSES       2'h2

// Init sequencer states
`define PVI_ST_UNINIT        3'h0
`define PVI_ST_WANT2         3'h1
`define PVI_ST_WANT3         3'h2
`define PVI_ST_WANT4         3'h3
`define PVI_ST_READY         3'h4

`endif

// [pvi_core.v]
// Vector byte generation and init word sequencing for an eight-level interrupt controller
// Summary of operation
// - Call mode first acknowledge drives call opcode, lone or master only
// - Spacing four: address 7..5, level, two zeros
// - Spacing eight: address 7..6, level, three zeros
// - Third call pulse drives stored high address
// - Vector mode: two pulses, never call opcode
// - Vector first pulse: freeze, cascade code, bus off
// - Vector second pulse: base top five, level
// - Two to four init words, then operation words
// - Select low, bit four high restarts init
// - First word resets edge detectors
// - First word clears masks, line seven lowest
// - First word clears special mask, reads pending
// - No fourth word zeroes fourth-word settings
// - Level trigger bit makes requests level sensitive
// - Spacing bit: one gives four, zero eight
// - Lone controller skips the third word
// - Master cascades remaining bytes to slave
// - Slave drives later bytes on id match
// - Role from pin, or fourth word when buffered
// - Buffered mode turns pin into transceiver enable
// - Special nesting bit selects special nesting
// - Auto finish bit selects automatic end
// - Auto finish clears service bit after last pulse
// - Vector pulse sets service; in edge mode it also clears pending
// - No request answers level seven, cascade idle
`include "pvi_regs.vh"

module pvi_core (
  // Clock, reset, enable
  input  wire       ref_clk_i,
  input  wire       rst_i,
  input  wire       clk_en_i,
  // Processor bus pins
  input  wire       cs_n_i,
  input  wire       wr_n_i,
  input  wire       rd_n_i,
  input  wire       register_select_line_i,
  input  wire [7:0] data_i,
  output reg  [7:0] data_o,
  output reg        data_oe_n_o,
  input  wire       ack_strobe_n_i,
  output reg        int_o,
  // Request inputs
  input  wire [7:0] request_lines_i,
  // Cascade pins
  input  wire [2:0] chain_id_lines_i,
  output reg  [2:0] chain_id_lines_o,
  output reg        chain_id_lines_oe_n_o,
  // Role strap or transceiver enable pin
  input  wire       role_or_transceiver_pin_i,
  output reg        role_or_transceiver_pin_o,
  output reg        role_or_transceiver_pin_oe_n_o
);

  // Two-stage synchronisers for every pin input
  reg       cs_n_m, wr_n_m, rd_n_m, sel_m, ack_n_m, role_m;
  reg       cs_n_s, wr_n_s, rd_n_s, sel_s, ack_n_s, role_s;
  reg [7:0] data_m, req_m, data_s, req_s;
  reg [2:0] casc_m, casc_s;

  // Edge history of synchronised strobes
  reg       wr_n_d, ack_n_d;
  reg [7:0] req_d;
  reg [7:0] wdata_reg;
  reg       wsel_reg;
  reg       wcs_reg;

  // Programmed words and state
  reg [2:0] state_reg;
  reg [7:0] init_word_one_reg;
  reg [7:0] vector_base_word_reg;
  reg [7:0] cascade_topology_word_reg;
  reg [7:0] mode_options_word_reg;
  reg [7:0] pending_bits_reg;
  reg [7:0] service_bits_reg;
  reg [7:0] mask_bits_reg;
  reg       special_mask_reg;
  reg       read_service_reg;

  // Acknowledge sequence state
  reg [1:0] pulse_cnt_reg;
  reg [2:0] level_reg;
  reg       spurious_reg;
  reg       cascaded_reg;
  reg       own_reg;

  // Write is taken on the trailing edge of the strobe, with select and data held from the low phase
  wire wr_done  = wr_n_s & ~wr_n_d & ~wcs_reg;
  // Named by the pin level: fall opens a pulse, rise closes it
  wire ack_fall = ~ack_n_s & ack_n_d;
  wire ack_rise = ack_n_s & ~ack_n_d;
  wire is_word1 = wr_done & ~wsel_reg & wdata_reg[`PVI_W1_MARK_BIT];
  wire ready    = (state_reg == `PVI_ST_READY);

  // Decoded mode fields
  wire level_mode  = init_word_one_reg[`PVI_W1_LEVEL_BIT];
  wire lone        = init_word_one_reg[`PVI_W1_LONE_BIT];
  wire space4      = init_word_one_reg[`PVI_W1_SPACE4_BIT];
  wire vec_mode    = mode_options_word_reg[`PVI_W4_VECMODE_BIT];
  wire auto_finish = mode_options_word_reg[`PVI_W4_AUTO_BIT];
  wire buffered    = mode_options_word_reg[`PVI_W4_BUF_BIT];
  wire nesting     = mode_options_word_reg[`PVI_W4_NEST_BIT];
  // Buffered mode takes role from the word; otherwise the pin strap decides
  wire is_master   = buffered ? mode_options_word_reg[`PVI_W4_MASTER_BIT] : role_s;
  wire [1:0] last_pulse = vec_mode ? `PVI_VEC_PULSES : `PVI_CALL_PULSES;
  // A master takes the level for a cascaded slave too, so its own service bit blocks repeats
  wire       grant     = ack_fall & ready & (pulse_cnt_reg == 2'h1) & ~spurious_reg &
                         (own_reg | cascaded_reg);
  wire [7:0] grant_vec = grant ? (8'h01 << level_reg) : 8'h00;

  // Fixed priority, line 0 highest, line 7 lowest
  reg [7:0] eligible;
  reg       any_req;
  reg [2:0] best;
  reg [2:0] top_isr;
  reg       blocked;
  reg       any_isr;
  integer   i;
  integer   j;
  always @* begin
    eligible = 8'h00;
    any_req  = 1'b0;
    best     = `PVI_FALLBACK_LEVEL;
    top_isr  = 3'h0;
    any_isr  = 1'b0;
    blocked  = 1'b0;
    for (i = 0; i < 8; i = i + 1) begin
      blocked = 1'b0;
      for (j = 0; j < 8; j = j + 1) begin
        // Special nesting lets a cascaded master reopen its own level
        if (service_bits_reg[j] && !(special_mask_reg && mask_bits_reg[j]) &&
            ((j < i) || (j == i && !(nesting && is_master))))
          blocked = 1'b1;
      end
      eligible[i] = pending_bits_reg[i] & ~mask_bits_reg[i] & ~blocked;
    end
    // Scan from lowest to highest so the highest priority is left standing
    for (i = 7; i >= 0; i = i - 1) begin
      if (eligible[i]) begin
        any_req = 1'b1;
        best    = i[2:0];
      end
      if (service_bits_reg[i]) begin
        any_isr = 1'b1;
        top_isr = i[2:0];
      end
    end
  end

  // Byte driven by this controller for the current acknowledge pulse
  reg [7:0] vec_byte;
  reg       vec_drive;
  always @* begin
    vec_byte  = 8'h00;
    vec_drive = 1'b0;
    if (!ack_n_s && pulse_cnt_reg != 2'h0) begin
      if (pulse_cnt_reg == 2'h1) begin
        // Slave never supplies the opcode; vector mode keeps the bus off
        vec_drive = ~vec_mode & (lone | is_master);
        vec_byte  = `PVI_CALL_OPCODE;
      end else begin
        vec_drive = own_reg;
        if (vec_mode)
          vec_byte = {vector_base_word_reg[7:3], level_reg};
        else if (pulse_cnt_reg == 2'h3)
          vec_byte = vector_base_word_reg;
        else if (space4)
          vec_byte = {init_word_one_reg[7:5], level_reg, 2'b00};
        else
          vec_byte = {init_word_one_reg[7:6], level_reg, 3'b000};
      end
    end
  end

  // Status reads stay off the bus during an acknowledge pulse
  wire rd_drive = ~rd_n_s & ~cs_n_s & ack_n_s;
  wire [7:0] rd_byte = sel_s ? mask_bits_reg :
                       (read_service_reg ? service_bits_reg : pending_bits_reg);

  // Pin synchronisers
  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      {cs_n_m, wr_n_m, rd_n_m, ack_n_m} <= 4'hF;
      {cs_n_s, wr_n_s, rd_n_s, ack_n_s} <= 4'hF;
      {sel_m, sel_s, role_m, role_s}    <= 4'h0;
      data_m <= 8'h00;
      data_s <= 8'h00;
      req_m  <= 8'h00;
      req_s  <= 8'h00;
      casc_m <= 3'h0;
      casc_s <= 3'h0;
    end else if (clk_en_i) begin
      {cs_n_m, wr_n_m, rd_n_m, ack_n_m} <= {cs_n_i, wr_n_i, rd_n_i, ack_strobe_n_i};
      {cs_n_s, wr_n_s, rd_n_s, ack_n_s} <= {cs_n_m, wr_n_m, rd_n_m, ack_n_m};
      sel_m  <= register_select_line_i;
      sel_s  <= sel_m;
      role_m <= role_or_transceiver_pin_i;
      role_s <= role_m;
      data_m <= data_i;
      data_s <= data_m;
      req_m  <= request_lines_i;
      req_s  <= req_m;
      casc_m <= chain_id_lines_i;
      casc_s <= casc_m;
    end
  end

  // Main state
  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      wr_n_d                    <= 1'b1;
      ack_n_d                   <= 1'b1;
      req_d                     <= 8'hFF;
      wdata_reg                 <= 8'h00;
      wsel_reg                  <= 1'b0;
      wcs_reg                   <= 1'b1;
      state_reg                 <= `PVI_ST_UNINIT;
      init_word_one_reg         <= `PVI_WORD_RST;
      vector_base_word_reg      <= `PVI_WORD_RST;
      cascade_topology_word_reg <= `PVI_WORD_RST;
      mode_options_word_reg     <= `PVI_WORD_RST;
      pending_bits_reg          <= 8'h00;
      service_bits_reg          <= 8'h00;
      mask_bits_reg             <= `PVI_MASK_RST;
      special_mask_reg          <= 1'b0;
      read_service_reg          <= 1'b0;
      pulse_cnt_reg             <= 2'h0;
      level_reg                 <= `PVI_FALLBACK_LEVEL;
      spurious_reg              <= 1'b0;
      cascaded_reg              <= 1'b0;
      own_reg                   <= 1'b0;
    end else if (clk_en_i) begin
      wr_n_d  <= wr_n_s;
      ack_n_d <= ack_n_s;
      req_d   <= req_s;
      // Capture write data while the strobe is low; taken at its trailing edge
      if (!wr_n_s) begin
        wdata_reg <= data_s;
        wsel_reg  <= sel_s;
        wcs_reg   <= cs_n_s;
      end

      // Request capture; a new edge wins over an acknowledge clear
      if (level_mode)
        pending_bits_reg <= req_s;
      else
        pending_bits_reg <= ((pending_bits_reg & ~grant_vec) | (req_s & ~req_d)) & req_s;

      // Acknowledge sequence
      if (ack_fall && ready) begin
        if (pulse_cnt_reg == 2'h0) begin
          // First pulse freezes the resolution result
          level_reg     <= any_req ? best : `PVI_FALLBACK_LEVEL;
          spurious_reg  <= ~any_req;
          cascaded_reg  <= ~lone & is_master & any_req & cascade_topology_word_reg[best];
          pulse_cnt_reg <= 2'h1;
        end else begin
          if (pulse_cnt_reg == 2'h1) begin
            if (grant)
              service_bits_reg[level_reg] <= 1'b1;
          end
          pulse_cnt_reg <= pulse_cnt_reg + 2'h1;
        end
      end
      // Ownership of bytes after the first is settled once the cascade code is stable
      if (ack_n_s && pulse_cnt_reg == 2'h1) begin
        if (lone || is_master)
          own_reg <= ~cascaded_reg;
        else
          own_reg <= (casc_s == cascade_topology_word_reg[2:0]);
      end
      // Last pulse closes the sequence; auto finish drops the bit it set
      if (ack_rise && pulse_cnt_reg == last_pulse) begin
        pulse_cnt_reg <= 2'h0;
        own_reg       <= 1'b0;
        if (auto_finish && !spurious_reg && (own_reg || cascaded_reg))
          service_bits_reg[level_reg] <= 1'b0;
      end

      // Register writes
      if (is_word1) begin
        init_word_one_reg <= wdata_reg;
        state_reg         <= `PVI_ST_WANT2;
        // Lines already high must fall and rise again
        req_d             <= 8'hFF;
        pending_bits_reg  <= 8'h00;
        mask_bits_reg     <= 8'h00;
        service_bits_reg  <= 8'h00;
        special_mask_reg  <= 1'b0;
        read_service_reg  <= 1'b0;
        // Init restart abandons any acknowledge sequence in flight
        pulse_cnt_reg     <= 2'h0;
        own_reg           <= 1'b0;
        if (!wdata_reg[`PVI_W1_NEED4_BIT])
          mode_options_word_reg <= 8'h00;
      end else if (wr_done) begin
        case (state_reg)
          `PVI_ST_WANT2: begin
            vector_base_word_reg <= wdata_reg;
            // Lone controller skips the cascade word
            if (!lone)
              state_reg <= `PVI_ST_WANT3;
            else if (init_word_one_reg[`PVI_W1_NEED4_BIT])
              state_reg <= `PVI_ST_WANT4;
            else
              state_reg <= `PVI_ST_READY;
          end
          `PVI_ST_WANT3: begin
            cascade_topology_word_reg <= wdata_reg;
            // Fourth word only when the first asked for it
            state_reg <= init_word_one_reg[`PVI_W1_NEED4_BIT] ? `PVI_ST_WANT4 : `PVI_ST_READY;
          end
          `PVI_ST_WANT4: begin
            mode_options_word_reg <= wdata_reg;
            state_reg             <= `PVI_ST_READY;
          end
          `PVI_ST_READY: begin
            // Operation words accepted any time after init
            if (wsel_reg)
              mask_bits_reg <= wdata_reg;
            else if (wdata_reg[`PVI_OP_SEL3_BIT]) begin
              if (wdata_reg[`PVI_OP_RDREG_BIT])
                read_service_reg <= wdata_reg[`PVI_OP_RDISR_BIT];
              if (wdata_reg[`PVI_OP_ESMM_BIT])
                special_mask_reg <= wdata_reg[`PVI_OP_SMM_BIT];
            end else if (wdata_reg[`PVI_OP_EOI_BIT]) begin
              // A grant in the same cycle keeps its bit: the set wins
              if (wdata_reg[`PVI_OP_SPEC_BIT]) begin
                if (!grant_vec[wdata_reg[2:0]])
                  service_bits_reg[wdata_reg[2:0]] <= 1'b0;
              end else if (any_isr && !grant_vec[top_isr])
                service_bits_reg[top_isr] <= 1'b0;
            end
          end
          default: state_reg <= `PVI_ST_UNINIT;
        endcase
      end
    end
  end

  // Registered pin drive
  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      data_o                         <= 8'h00;
      data_oe_n_o                    <= 1'b1;
      int_o                          <= 1'b0;
      chain_id_lines_o               <= `PVI_CASC_IDLE;
      chain_id_lines_oe_n_o          <= 1'b1;
      role_or_transceiver_pin_o      <= 1'b1;
      role_or_transceiver_pin_oe_n_o <= 1'b1;
    end else if (clk_en_i) begin
      // Vector bytes take the bus over status reads
      data_o      <= vec_drive ? vec_byte : (rd_drive ? rd_byte : 8'h00);
      data_oe_n_o <= ~(vec_drive | rd_drive);
      // Request is withdrawn once the first pulse has frozen the level
      int_o       <= ready & any_req & (pulse_cnt_reg == 2'h0);
      // Master drives cascade code only for a slave-owned level
      chain_id_lines_oe_n_o <= ~(ready & ~lone & is_master);
      chain_id_lines_o      <= cascaded_reg && pulse_cnt_reg != 2'h0 ? level_reg : `PVI_CASC_IDLE;
      // Transceiver enable is active low while data is driven out
      role_or_transceiver_pin_oe_n_o <= ~buffered;
      role_or_transceiver_pin_o      <= ~(vec_drive | rd_drive);
    end
  end

endmodule // pvi_core

// [pvi_core_asserts.sv]
// Port-level temporal checks for the vector and init word controller
module pvi_core_asserts (
  // Clock and reset
  input logic       ref_clk_i,
  input logic       rst_i,
  // Host strobes and requests
  input logic       cs_n_i,
  input logic       wr_n_i,
  input logic       rd_n_i,
  input logic       ack_strobe_n_i,
  input logic [7:0] request_lines_i,
  // Device outputs
  input logic       data_oe_n_o,
  input logic       int_o,
  input logic [2:0] chain_id_lines_o,
  input logic       chain_id_lines_oe_n_o,
  input logic       role_or_transceiver_pin_oe_n_o
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (rst_i);
  // Cycles since each cause was last seen; saturates so long idles stay quiet
  logic [3:0] sq_reg, kq_reg, wq_reg, rq_reg;
  logic       seen_reg;
  function automatic logic [3:0] step(input logic hit, input logic [3:0] c);
    return hit ? 4'h0 : c + {3'h0, c != 4'hf};
  endfunction
  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      sq_reg <= 4'hf;
      kq_reg <= 4'hf;
      wq_reg <= 4'hf;
      rq_reg <= 4'hf;
      seen_reg <= 1'b0;
    end else begin
      sq_reg <= step(!ack_strobe_n_i || (!rd_n_i && !cs_n_i), sq_reg);
      kq_reg <= step(!ack_strobe_n_i, kq_reg);
      wq_reg <= step(!wr_n_i && !cs_n_i, wq_reg);
      rq_reg <= step(|request_lines_i, rq_reg);
      seen_reg <= seen_reg | (!wr_n_i && !cs_n_i);
    end
  end
  chk_oe_cause: assert property ($fell(data_oe_n_o) |-> !ack_strobe_n_i || (!rd_n_i && !cs_n_i))
    else $error("data bus enabled without a strobe");
  chk_oe_release: assert property (!data_oe_n_o |-> sq_reg < 4'h8)
    else $error("data bus still driven long after strobes ended");
  chk_int_drop_ack: assert property ($fell(ack_strobe_n_i) && int_o |-> ##[1:6] !int_o)
    else $error("interrupt not withdrawn after acknowledge");
  chk_casc_window: assert property (chain_id_lines_o != 3'h0 |-> kq_reg < 4'hc)
    else $error("cascade code shown outside an acknowledge sequence");
  chk_casc_hold: assert property (chain_id_lines_o != 3'h0 && $past(chain_id_lines_o) != 3'h0
    |-> $stable(chain_id_lines_o))
    else $error("cascade code changed within a sequence");
  chk_role_after_write: assert property ($changed(role_or_transceiver_pin_oe_n_o) |-> wq_reg < 4'hc)
    else $error("role pin direction changed without a write");
  chk_int_cause: assert property ($rose(int_o) |-> rq_reg < 4'h8)
    else $error("interrupt raised with no request line high");
  chk_int_after_init: assert property (int_o |-> seen_reg)
    else $error("interrupt raised before any init write");
endmodule // pvi_core_asserts

bind pvi_core pvi_core_asserts pvi_core_asserts_inst (
  .ref_clk_i, .rst_i, .cs_n_i, .wr_n_i, .rd_n_i, .ack_strobe_n_i, .request_lines_i, .data_oe_n_o,
  .int_o, .chain_id_lines_o, .chain_id_lines_oe_n_o, .role_or_transceiver_pin_oe_n_o
);

// [pvi_host.sv]
// Host processor model: register writes, reads and acknowledge pulses
module pvi_host (
  // Clock
  input  logic       ref_clk_i,
  // Device answer
  input  logic [7:0] data_i,
  input  logic       data_oe_n_i,
  // Strobes and data toward the device
  output logic       cs_n_o,
  output logic       wr_n_o,
  output logic       rd_n_o,
  output logic       sel_o,
  output logic [7:0] data_o,
  output logic       ack_n_o
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    cs_n_o = 1'b1;
    wr_n_o = 1'b1;
    rd_n_o = 1'b1;
    ack_n_o = 1'b1;
    sel_o = 1'b0;
    data_o = 8'h00;
  end
  task automatic idle(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask
  // Strobes stay low eight cycles, well past the input synchronisers
  task automatic wr(input logic sel, input logic [7:0] d);
    idle(1);
    cs_n_o = 1'b0;
    sel_o = sel;
    data_o = d;
    wr_n_o = 1'b0;
    idle(8);
    wr_n_o = 1'b1;
    idle(1);
    cs_n_o = 1'b1;
    data_o = ~d;
    idle(6);
  endtask
  task automatic rd(input logic sel, output logic [8:0] q);
    idle(1);
    cs_n_o = 1'b0;
    sel_o = sel;
    rd_n_o = 1'b0;
    idle(8);
    q = {data_oe_n_i, data_i};
    rd_n_o = 1'b1;
    cs_n_o = 1'b1;
    idle(6);
  endtask
  // Byte is taken while the pulse is still low, where it stands
  task automatic ack(output logic [8:0] q);
    idle(1);
    ack_n_o = 1'b0;
    idle(8);
    q = {data_oe_n_i, data_i};
    ack_n_o = 1'b1;
    idle(8);
  endtask
endmodule // pvi_host

// [pvi_core_tb.sv]
// Self-checking bench for the vector and init word controller
module pvi_core_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic       ref_clk_i, rst_i, clk_en_i, cs_n_i, wr_n_i, rd_n_i, register_select_line_i;
  logic       ack_strobe_n_i, int_o, data_oe_n_o, chain_id_lines_oe_n_o, role_or_transceiver_pin_i;
  logic       role_or_transceiver_pin_o, role_or_transceiver_pin_oe_n_o;
  logic [7:0] data_i, data_o, request_lines_i;
  logic [2:0] chain_id_lines_i, chain_id_lines_o;
  logic [8:0] q;
  int         fails, checked, cycles;
  int         en_cnt, oe_cnt, e0, o0;

  pvi_core pvi_core_inst (
    .ref_clk_i, .rst_i, .clk_en_i, .cs_n_i, .wr_n_i, .rd_n_i, .register_select_line_i,
    .data_i, .data_o, .data_oe_n_o, .ack_strobe_n_i, .int_o, .request_lines_i,
    .chain_id_lines_i, .chain_id_lines_o, .chain_id_lines_oe_n_o,
    .role_or_transceiver_pin_i, .role_or_transceiver_pin_o, .role_or_transceiver_pin_oe_n_o
  );
  pvi_host pvi_host_inst (
    .ref_clk_i, .data_i(data_o), .data_oe_n_i(data_oe_n_o), .cs_n_o(cs_n_i), .wr_n_o(wr_n_i),
    .rd_n_o(rd_n_i), .sel_o(register_select_line_i), .data_o(data_i), .ack_n_o(ack_strobe_n_i)
  );

  initial begin
    ref_clk_i = 1'b0;
    forever #2.5 ref_clk_i = ~ref_clk_i;
  end
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // The whole sequence needs under 2000 cycles
  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 6000) begin
      fails++;
      close_out;
    end
  end
  // Transceiver enable must be active in exactly the cycles the data bus is driven
  always @(posedge ref_clk_i) begin
    if (!role_or_transceiver_pin_o) en_cnt++;
    if (!data_oe_n_o) oe_cnt++;
  end
  task automatic chk(input string what, input logic [8:0] seen, input logic [8:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic gap(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask
  task automatic wait_int;
    int n;
    n = 0;
    while (int_o !== 1'b1 && n < 40) begin
      gap(1);
      n++;
    end
    chk("int_o", int_o, 9'h001);
  endtask
  task automatic ack_chk(input string what, input logic [8:0] exp);
    logic [8:0] r;
    pvi_host_inst.ack(r);
    chk(what, r, exp);
  endtask
  task automatic rd_chk(input logic sel, input string what, input logic [8:0] exp);
    logic [8:0] r;
    pvi_host_inst.rd(sel, r);
    chk(what, r, exp);
  endtask
  task automatic init(input logic [7:0] w1, w2, w3, w4);
    pvi_host_inst.wr(1'b0, w1);
    pvi_host_inst.wr(1'b1, w2);
    if (!w1[1]) pvi_host_inst.wr(1'b1, w3);
    if (w1[0]) pvi_host_inst.wr(1'b1, w4);
  endtask

  initial begin
    rst_i = 1'b1;
    clk_en_i = 1'b1;
    request_lines_i = 8'h00;
    chain_id_lines_i = 3'h0;
    role_or_transceiver_pin_i = 1'b1;
    gap(20);
    rst_i = 1'b0;
    // Two-pulse vector mode with auto finish
    init(8'h13, 8'h48, 8'h00, 8'h03);
    request_lines_i = 8'h40;
    wait_int;
    pvi_host_inst.ack(q);
    chk("pulse one oe_n", {8'h00, q[8]}, 9'h001);
    ack_chk("vector", 9'h04e);
    pvi_host_inst.wr(1'b0, 8'h0b);
    rd_chk(1'b0, "service", 9'h000);
    request_lines_i = 8'h00;
    pvi_host_inst.ack(q);
    ack_chk("spurious", 9'h04f);
    // Back to call mode since no fourth word follows
    init(8'hb6, 8'ha0, 8'h00, 8'h00);
    request_lines_i = 8'h08;
    wait_int;
    rd_chk(1'b0, "pending", 9'h008);
    rd_chk(1'b1, "mask", 9'h000);
    ack_chk("call", 9'h0cd);
    ack_chk("low four", 9'h0ac);
    ack_chk("high", 9'h0a0);
    pvi_host_inst.wr(1'b0, 8'h0b);
    rd_chk(1'b0, "service", 9'h008);
    pvi_host_inst.wr(1'b0, 8'h20);
    rd_chk(1'b0, "after eoi", 9'h000);
    pvi_host_inst.wr(1'b1, 8'h08);
    rd_chk(1'b1, "mask set", 9'h008);
    // Restart with line three still high: no fresh edge, no interrupt
    init(8'hd2, 8'hc0, 8'h00, 8'h00);
    gap(12);
    chk("int_o", {8'h00, int_o}, 9'h000);
    request_lines_i = 8'h00;
    gap(4);
    request_lines_i = 8'h20;
    wait_int;
    ack_chk("call", 9'h0cd);
    ack_chk("low eight", 9'h0e8);
    ack_chk("high", 9'h0c0);
    // Held lines are seen in level mode; line zero outranks line seven
    request_lines_i = 8'h81;
    init(8'h9a, 8'h80, 8'h00, 8'h00);
    wait_int;
    ack_chk("call", 9'h0cd);
    ack_chk("low eight", 9'h080);
    ack_chk("high", 9'h080);
    request_lines_i = 8'h00;
    // Master from the pin, slave on line three
    init(8'h11, 8'h20, 8'h08, 8'h01);
    request_lines_i = 8'h08;
    wait_int;
    pvi_host_inst.ack(q);
    chk("cascade", {5'h00, chain_id_lines_oe_n_o, chain_id_lines_o}, 9'h003);
    pvi_host_inst.ack(q);
    chk("master oe_n", {8'h00, q[8]}, 9'h001);
    chk("role oe_n", {8'h00, role_or_transceiver_pin_oe_n_o}, 9'h001);
    request_lines_i = 8'h00;
    // Buffered slave: role bit overrides the pin
    init(8'h11, 8'h90, 8'h05, 8'h09);
    chk("role oe_n", {8'h00, role_or_transceiver_pin_oe_n_o}, 9'h000);
    request_lines_i = 8'h02;
    wait_int;
    chain_id_lines_i = 3'h5;
    e0 = en_cnt;
    o0 = oe_cnt;
    pvi_host_inst.ack(q);
    ack_chk("slave", 9'h091);
    chk("enable cycles", 9'(en_cnt - e0), 9'(oe_cnt - o0));
    chain_id_lines_i = 3'h2;
    close_out;
  end
endmodule // pvi_core_tb
